// ===== pkg/can_timing_pkg.sv
package can_timing_pkg;

  // ----------------------------------------------------------------
  // register map, byte addresses on the axi4-lite slave
  // ----------------------------------------------------------------
  localparam int unsigned   ADDR_W        = 4;
  localparam logic [3:0]    OFF_TIMING    = 4'h0;
  localparam logic [3:0]    OFF_CONTROL   = 4'h4;
  localparam logic [3:0]    OFF_STATUS    = 4'h8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned   PRESC_LSB     = 0;
  localparam int unsigned   SPAN1_LSB     = 16;
  localparam int unsigned   SPAN2_LSB     = 20;
  localparam int unsigned   JUMP_LSB      = 24;
  localparam int unsigned   CTRL_CFG_BIT  = 0;
  localparam int unsigned   CTRL_TX_BIT   = 1;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [9:0]    PRESC_RST     = 10'h000;
  localparam logic [3:0]    SPAN1_RST     = 4'h4;  // stored minus one: 5 quanta
  localparam logic [2:0]    SPAN2_RST     = 3'h1;  // stored minus one: 2 quanta
  localparam logic [1:0]    JUMP_RST      = 2'h0;  // stored minus one: 1 quantum
  localparam logic [3:0]    IDLE_BITS     = 4'hb;  // recessive bits before idle
  localparam int unsigned   CLK_PERIOD_NS = 20;

  localparam logic [1:0]    RESP_OKAY     = 2'b00;
  localparam logic [1:0]    RESP_SLVERR   = 2'b10;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] resync_jump_limit;  // quanta minus one, 1..4
    logic [2:0] phase_span_two;     // quanta minus one, 2..8
    logic [3:0] phase_span_one;     // quanta minus one, 4..16
    logic [9:0] prescale;           // divide by prescale + 1
  } timing_cfg_s;

  typedef struct packed {
    logic tx_start;       // pulse: transmission may begin
    logic bit_start;      // pulse: sync segment entered
    logic sample_strobe;  // pulse: bus level latched
    logic rx_bit;         // last latched bus level
    logic bus_idle;       // level: idle condition reached
  } bit_events_s;

  typedef enum logic [1:0] {ST_SYNC, ST_SPAN1, ST_SPAN2} seg_state_e;

endpackage : can_timing_pkg

// ===== hdl/can_tq_prescaler.sv
`timescale 1ns/1ps
module can_tq_prescaler
  import can_timing_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       hold,
  input  wire logic [9:0] divide,
  output logic            tq_tick
);

  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;

  // ----------------------------------------------------------------
  // quantum divider
  // ----------------------------------------------------------------
  // tick once every divide + 1 clocks; hold restarts the phase
  assign tq_tick = ce && !hold && (cnt_reg == divide);

  always_comb
  begin
    cnt_next = cnt_reg;
    if (hold)
      cnt_next = '0;
    else if (tq_tick)
      cnt_next = '0;
    else if (cnt_reg < divide)
      cnt_next = cnt_reg + 10'h001;
    else
      cnt_next = '0;  // divide lowered under us
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= '0;
    else if (ce)
      cnt_reg <= cnt_next;
  end

  a_tick_spacing : assert property (@(posedge aclk) disable iff (!aresetn)
    (tq_tick && divide != 10'h000) |=> !tq_tick)
    else $error("quantum tick repeated under a divider above one");

endmodule : can_tq_prescaler

// ===== hdl/can_bit_timing.sv
// Contract
// - sync segment is one quantum; idle falling edge hard-synchronises the bit
// - sample instant follows the programmed phase span lengths
// - resync corrects phase error by at most the jump limit
// - quantum clock is system clock over prescale plus one, prescale 0..1023
// - bit rate is system clock over divider times quanta per bit
// - transmission starts only in bus idle, not intermission or suspend
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module can_bit_timing
  import can_timing_pkg::*;
(
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  input  wire logic [can_timing_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [can_timing_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          can_rx,
  output can_timing_pkg::bit_events_s        events
);
  import can_timing_pkg::*;

  // ----------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------
  logic                aw_full_reg, aw_full_next;
  logic [ADDR_W-1:0]   aw_addr_reg, aw_addr_next;
  logic                w_full_reg, w_full_next;
  logic [31:0]         w_data_reg, w_data_next;
  logic [3:0]          w_strb_reg, w_strb_next;
  logic                bvalid_reg, bvalid_next;
  logic [1:0]          bresp_reg, bresp_next;
  logic                rvalid_reg, rvalid_next;
  logic [31:0]         rdata_reg, rdata_next;
  logic [1:0]          rresp_reg, rresp_next;
  timing_cfg_s         cfg_reg, cfg_next;
  logic                cfg_mode_reg, cfg_mode_next;
  logic                tx_req_reg, tx_req_next;

  // ----------------------------------------------------------------
  // bit timing state
  // ----------------------------------------------------------------
  seg_state_e          state_reg, state_next;
  logic [4:0]          cnt_reg, cnt_next;
  logic [4:0]          span1_len_reg, span1_len_next;
  logic [4:0]          span2_len_reg, span2_len_next;
  logic                resynced_reg, resynced_next;
  logic                rx_prev_reg, rx_prev_next;
  logic [3:0]          rec_cnt_reg, rec_cnt_next;
  bit_events_s         ev_reg, ev_next;

  logic                tq_tick;
  logic                falling;
  logic                hard_sync;
  logic                sync_jump;
  logic [4:0]          span1_q, span2_q, jump_q;
  logic [31:0]         timing_word;

  assign span1_q     = {1'b0, cfg_reg.phase_span_one} + 5'h01;
  assign span2_q     = {2'b00, cfg_reg.phase_span_two} + 5'h01;
  assign jump_q      = {3'b000, cfg_reg.resync_jump_limit} + 5'h01;
  assign timing_word = {6'h00, cfg_reg.resync_jump_limit, 1'b0, cfg_reg.phase_span_two,
                        cfg_reg.phase_span_one, 6'h00, cfg_reg.prescale};

  // merge a written word into an old one under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = new_w[8*b +: 8];
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  // address and data are parked separately so either may come first
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb
  begin
    logic [31:0] word;
    word          = '0;
    aw_full_next  = aw_full_reg;
    aw_addr_next  = aw_addr_reg;
    w_full_next   = w_full_reg;
    w_data_next   = w_data_reg;
    w_strb_next   = w_strb_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    rvalid_next   = rvalid_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    cfg_next      = cfg_reg;
    cfg_mode_next = cfg_mode_reg;
    tx_req_next   = tx_req_reg;
    if (ev_reg.tx_start)
      tx_req_next = 1'b0;  // granted; a new software set below still wins
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (aw_full_reg && w_full_reg)
    begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = RESP_OKAY;
      case (aw_addr_reg)
        OFF_TIMING:
        begin
          // changes outside reset mode are dropped so a live bit never tears
          if (cfg_mode_reg)
          begin
            word     = merge(timing_word, w_data_reg, w_strb_reg);
            cfg_next = {word[JUMP_LSB +: 2], word[SPAN2_LSB +: 3],
                        word[SPAN1_LSB +: 4], word[PRESC_LSB +: 10]};
          end
        end
        OFF_CONTROL:
        begin
          if (w_strb_reg[0])
          begin
            cfg_mode_next = w_data_reg[CTRL_CFG_BIT];
            if (w_data_reg[CTRL_TX_BIT])
              tx_req_next = 1'b1;
          end
        end
        OFF_STATUS: ;
        default:
          bresp_next = RESP_SLVERR;
      endcase
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      case (s_axi_araddr)
        OFF_TIMING:  rdata_next = timing_word;
        OFF_CONTROL: rdata_next = {30'h0, tx_req_reg, cfg_mode_reg};
        OFF_STATUS:  rdata_next = {27'h0, state_reg == ST_SYNC, tx_req_reg,
                                   cfg_mode_reg, ev_reg.bus_idle, ev_reg.rx_bit};
        default:
        begin
          rdata_next = '0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg  <= 1'b0;
      aw_addr_reg  <= '0;
      w_full_reg   <= 1'b0;
      w_data_reg   <= '0;
      w_strb_reg   <= '0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= '0;
      rresp_reg    <= RESP_OKAY;
      cfg_reg      <= {JUMP_RST, SPAN2_RST, SPAN1_RST, PRESC_RST};
      cfg_mode_reg <= 1'b1;
      tx_req_reg   <= 1'b0;
    end
    else if (ce)
    begin
      aw_full_reg  <= aw_full_next;
      aw_addr_reg  <= aw_addr_next;
      w_full_reg   <= w_full_next;
      w_data_reg   <= w_data_next;
      w_strb_reg   <= w_strb_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      cfg_reg      <= cfg_next;
      cfg_mode_reg <= cfg_mode_next;
      tx_req_reg   <= tx_req_next;
    end
  end

  // ----------------------------------------------------------------
  // quantum clock and edge detection
  // ----------------------------------------------------------------
  assign falling   = rx_prev_reg && !can_rx;
  assign hard_sync = ce && !cfg_mode_reg && falling && ev_reg.bus_idle;
  // edge in span two close to its end: the edge becomes the next sync
  assign sync_jump = ce && !cfg_mode_reg && falling && !ev_reg.bus_idle && !resynced_reg
                     && state_reg == ST_SPAN2 && (span2_len_reg - cnt_reg) <= jump_q;

  can_tq_prescaler u_prescaler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .hold    (cfg_mode_reg || hard_sync || sync_jump),
    .divide  (cfg_reg.prescale),
    .tq_tick (tq_tick)
  );

  // ----------------------------------------------------------------
  // segment sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [4:0] err;
    err            = cnt_reg + 5'h01;
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    span1_len_next = span1_len_reg;
    span2_len_next = span2_len_reg;
    resynced_next  = resynced_reg;
    rx_prev_next   = can_rx;
    rec_cnt_next   = rec_cnt_reg;
    ev_next        = ev_reg;
    ev_next.tx_start      = 1'b0;
    ev_next.bit_start     = 1'b0;
    ev_next.sample_strobe = 1'b0;
    ev_next.bus_idle      = (rec_cnt_reg == IDLE_BITS);
    if (cfg_mode_reg)
    begin
      state_next   = ST_SYNC;
      cnt_next     = '0;
      rec_cnt_next = '0;
    end
    else if (hard_sync || sync_jump)
    begin
      // the edge quantum stands in for the sync segment
      state_next     = ST_SPAN1;
      cnt_next       = '0;
      span1_len_next = span1_q;
      span2_len_next = span2_q;
      resynced_next  = 1'b0;
      ev_next.bit_start = 1'b1;
    end
    else
    begin
      if (falling && !resynced_reg && state_reg == ST_SPAN1)
      begin
        // late edge: stretch span one by the error, capped
        span1_len_next = span1_len_reg + ((err < jump_q) ? err : jump_q);
        resynced_next  = 1'b1;
      end
      else if (falling && !resynced_reg && state_reg == ST_SPAN2)
      begin
        span2_len_next = span2_len_reg - jump_q;
        resynced_next  = 1'b1;
      end
      if (tq_tick)
        case (state_reg)
          ST_SYNC:
          begin
            state_next     = ST_SPAN1;
            cnt_next       = '0;
            span1_len_next = span1_q;
            span2_len_next = span2_q;
            resynced_next  = 1'b0;
          end
          ST_SPAN1:
          begin
            if (cnt_reg >= span1_len_next - 5'h01)
            begin
              state_next            = ST_SPAN2;
              cnt_next              = '0;
              ev_next.sample_strobe = 1'b1;
              ev_next.rx_bit        = can_rx;
              rec_cnt_next = !can_rx ? 4'h0 : (rec_cnt_reg == IDLE_BITS) ? IDLE_BITS
                             : rec_cnt_reg + 4'h1;
            end
            else
              cnt_next = cnt_reg + 5'h01;
          end
          ST_SPAN2:
          begin
            if (cnt_reg >= span2_len_next - 5'h01)
            begin
              state_next        = ST_SYNC;
              cnt_next          = '0;
              ev_next.bit_start = 1'b1;
              ev_next.tx_start  = tx_req_reg && ev_reg.bus_idle;
            end
            else
              cnt_next = cnt_reg + 5'h01;
          end
          default:
          begin
            state_next = ST_SYNC;
            cnt_next   = '0;
          end
        endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg     <= ST_SYNC;
      cnt_reg       <= '0;
      span1_len_reg <= '0;
      span2_len_reg <= '0;
      resynced_reg  <= 1'b0;
      rx_prev_reg   <= 1'b1;
      rec_cnt_reg   <= '0;
      ev_reg        <= '0;
    end
    else if (ce)
    begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      span1_len_reg <= span1_len_next;
      span2_len_reg <= span2_len_next;
      resynced_reg  <= resynced_next;
      rx_prev_reg   <= rx_prev_next;
      rec_cnt_reg   <= rec_cnt_next;
      ev_reg        <= ev_next;
    end
  end

  assign events = ev_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_sync_one_tq : assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && tq_tick && state_reg == ST_SYNC && !cfg_mode_reg) |=> state_reg == ST_SPAN1)
    else $error("sync segment outlasted one quantum");

  a_hard_sync_edge : assert property (@(posedge aclk) disable iff (!aresetn)
    hard_sync |=> (state_reg == ST_SPAN1 && cnt_reg == 5'h00 && events.bit_start))
    else $error("idle falling edge did not restart the bit");

  a_sample_point : assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(events.sample_strobe) |-> ($past(state_reg) == ST_SPAN1 && state_reg == ST_SPAN2
                                     && cnt_reg == 5'h00))
    else $error("bus level latched away from the end of span one");

  a_span1_jump_cap : assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_SPAN1 && !cfg_mode_reg) |-> span1_len_reg <= span1_q + jump_q)
    else $error("span one stretched beyond the jump limit");

  a_span2_jump_cap : assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ST_SPAN2 && !cfg_mode_reg) |-> span2_len_reg + jump_q >= span2_q)
    else $error("span two shortened beyond the jump limit");

  a_tx_when_idle : assert property (@(posedge aclk) disable iff (!aresetn)
    events.tx_start |-> ($past(events.bus_idle) && events.bit_start && state_reg == ST_SYNC))
    else $error("transmission granted outside bus idle");

  a_cfg_hold : assert property (@(posedge aclk) disable iff (!aresetn)
    // on exit a divider of one ticks at once, the prescaler having been held at zero
    (ce && cfg_mode_reg) |=> (state_reg == ST_SYNC && cnt_reg == 5'h00
                              && tq_tick == (ce && !cfg_mode_reg && cfg_reg.prescale == 10'h000)))
    else $error("bit timing ran during reset mode");

  a_sample_once : assert property (@(posedge aclk) disable iff (!aresetn)
    events.sample_strobe |=> !events.sample_strobe [*2])
    else $error("more than one sample in a bit");

endmodule : can_bit_timing

// ===== testbench/can_node_model.sv
`timescale 1ns/1ps
module can_node_model (
  input  wire logic aclk,
  input  wire logic send,
  output logic      can_rx
);
  logic [3:0] hold_cnt = 4'h0;

  // ----------------------------------------------------------------
  // far node: one dominant burst per request, bus pulled recessive otherwise
  // ----------------------------------------------------------------
  // burst asked for while idle for the hard sync, and outside idle at random offsets for the resync edges
  always_ff @(posedge aclk)
  begin
    if (send)
      hold_cnt <= 4'hc;
    else if (hold_cnt != 4'h0)
      hold_cnt <= hold_cnt - 4'h1;
  end
  assign can_rx = (hold_cnt == 4'h0);  // released line reads recessive
endmodule : can_node_model

// ===== testbench/can_bit_timing_prescaler_tb.sv
`timescale 1ns/1ps
module can_bit_timing_prescaler_tb;
  import can_timing_pkg::*;
  localparam int EV_TX = 4;
  localparam int EV_BS = 3;
  localparam int EV_SS = 2;
  logic aclk, aresetn, ce, send, can_rx;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  bit_events_s events;
  int n_fail, n_compared, cyc, i, p, s1, s2, j, a, b, c;

  can_bit_timing uut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .can_rx(can_rx), .events(events));
  can_node_model far_node (.aclk(aclk), .send(send), .can_rx(can_rx));

  // ----------------------------------------------------------------
  // clock, timeout and reporting
  // ----------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  end
  // ceiling well above the slowest bit lengths used below
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_fail++;
      close_out();
    end
  end
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // axi4-lite master: flags sampled at the falling edge, released after the taking edge
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] ad, input logic [31:0] dat, output logic [1:0] rs);
    logic aw_p, w_p, b_p, aw_t, w_t, b_t;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    b_p = 1'b1;
    while (aw_p || w_p || b_p)
    begin
      @(negedge aclk);
      aw_t = aw_p && s_axi_awready;
      w_t = w_p && s_axi_wready;
      b_t = s_axi_bvalid;
      if (b_t)
        rs = s_axi_bresp;
      @(posedge aclk);
      if (aw_t)
        s_axi_awvalid <= 1'b0;
      if (w_t)
        s_axi_wvalid <= 1'b0;
      if (b_t)
        s_axi_bready <= 1'b0;
      aw_p = aw_p && !aw_t;
      w_p = w_p && !w_t;
      b_p = b_p && !b_t;
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] ad, output logic [31:0] dat, output logic [1:0] rs);
    logic a_p, r_p, a_t, r_t;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    a_p = 1'b1;
    r_p = 1'b1;
    while (a_p || r_p)
    begin
      @(negedge aclk);
      a_t = a_p && s_axi_arready;
      r_t = s_axi_rvalid;
      if (r_t)
        {dat, rs} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (a_t)
        s_axi_arvalid <= 1'b0;
      if (r_t)
        s_axi_rready <= 1'b0;
      a_p = a_p && !a_t;
      r_p = r_p && !r_t;
    end
  endtask : axi_rd
  // cycles until an event bit shows, bounded
  task automatic wait_ev(input int k, output int n);
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end while (events[k] !== 1'b1 && n < 3000);
  endtask : wait_ev
  function automatic logic [31:0] pack_cfg(int pp, int q1, int q2, int qj);
    return 32'(pp) | (32'(q1 - 1) << 16) | (32'(q2 - 1) << 20) | (32'(qj - 1) << 24);
  endfunction : pack_cfg

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {n_fail, n_compared, cyc} = '0;
    {aresetn, send, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    i = $urandom(32'hbc73);
    axi_rd(OFF_TIMING, d, r);
    chk(d, 32'h0014_0000, "timing reset value");
    axi_rd(OFF_CONTROL, d, r);
    chk(d[0], 1'b1, "starts in config mode");
    axi_rd(4'hc, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk(r, RESP_SLVERR, "unmapped read response");
    axi_wr(4'hc, 32'h0, r);
    chk(r, RESP_SLVERR, "unmapped write response");
    $display("test registers done");
    // corner configs first, then random legal ones
    for (i = 0; i < 5; i++)
    begin
      p = (i < 2) ? 0 : $urandom % 4;
      s2 = (i == 0) ? 2 : (i == 1) ? 8 : 2 + $urandom % 7;
      s1 = (i == 0) ? 5 : (i == 1) ? 16 : s2 + 1 + $urandom % (16 - s2);
      if (1 + s1 + s2 < 8)
        s1 = 7 - s2;
      j = (i == 1) ? 4 : 1 + $urandom % ((s2 < 4) ? s2 : 4);
      v = pack_cfg(p, s1, s2, j);
      axi_wr(OFF_CONTROL, 32'h1, r);
      axi_wr(OFF_TIMING, v, r);
      chk(r, RESP_OKAY, "timing write response");
      axi_rd(OFF_TIMING, d, r);
      chk(d, v, "timing readback");
      axi_wr(OFF_CONTROL, 32'h0, r);
      wait_ev(EV_BS, c);
      chk(c <= (p + 1) * 25 + 8, 1, "bit timing restarts");
      wait_ev(EV_SS, a);
      wait_ev(EV_BS, b);
      chk(a + b, (p + 1) * (1 + s1 + s2), "bit period");
      if (p == 0)
        chk(a, 1 + s1, "sample offset");
      $display("test config %0d done", i);
    end
    axi_wr(OFF_TIMING, 32'h0, r);
    axi_rd(OFF_TIMING, d, r);
    chk(d, v, "timing write outside config");
    axi_wr(OFF_CONTROL, 32'h1, r);
    a = 0;
    repeat (200)
    begin
      @(negedge aclk);
      a += events.bit_start;
    end
    chk(a, 0, "frozen in config");
    axi_rd(OFF_STATUS, d, r);
    chk(d[2], 1'b1, "status config");
    axi_wr(OFF_TIMING, pack_cfg(0, 4, 3, 2), r);
    axi_wr(OFF_CONTROL, 32'h0, r);
    wait_ev(0, c);
    chk(c < 3000, 1, "bus idle reached");
    axi_wr(OFF_CONTROL, 32'h2, r);
    wait_ev(EV_TX, c);
    chk({events.bit_start, events.bus_idle}, 2'b11, "tx start at idle boundary");
    axi_rd(OFF_CONTROL, d, r);
    chk(d[1], 1'b0, "tx request cleared");
    $display("test transmit done");
    repeat ($urandom % 7) @(posedge aclk);
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    wait_ev(EV_BS, c);
    chk(c <= 4, 1, "hard sync on idle edge");
    wait_ev(EV_SS, c);
    chk(c >= 3 && c <= 5, 1, "sample after hard sync");
    chk(events.rx_bit, 1'b0, "dominant latched");
    $display("test hard sync done");
    // clock enable low: no pulse may appear while frozen
    @(posedge aclk);
    ce <= 1'b0;
    a = 0;
    repeat (40)
    begin
      @(negedge aclk);
      a += events.bit_start + events.sample_strobe;
    end
    @(posedge aclk);
    ce <= 1'b1;
    chk(a, 0, "frozen while clock enable low");
    $display("test clock enable done");
    // non-idle edges at random offsets: 8 quanta bit moves by the jump of 2 at most
    for (i = 0; i < 6; i++)
    begin
      while (can_rx !== 1'b1)
        @(posedge aclk);
      wait_ev(EV_BS, c);
      j = $urandom % 7;
      repeat (j + 1) @(posedge aclk);
      send <= 1'b1;
      @(posedge aclk);
      send <= 1'b0;
      wait_ev(EV_BS, a);
      chk(a + j + 1 >= 6 && a + j + 1 <= 10, 1, "resync within jump");
    end
    $display("test resync done");
    close_out();
  end
endmodule : can_bit_timing_prescaler_tb
